//--- src/fie_cfg_regs.vh
// Register offsets, field positions and reset values of the fault enable and self-test configuration bank
`ifndef FIE_CFG_REGS_VH
`define FIE_CFG_REGS_VH
`define FIE_ADDR_SELF_TEST_RUN_CONFIG 8'h12
`define FIE_ADDR_FAST_UNDERVOLT_IRQ_ENABLE 8'h13
`define FIE_ADDR_SLOW_UNDERVOLT_IRQ_ENABLE 8'h14
`define FIE_ADDR_FAST_OVERVOLT_IRQ_ENABLE 8'h15
`define FIE_ADDR_SLOW_OVERVOLT_IRQ_ENABLE 8'h16
`define FIE_ADDR_CONTROL_FAULT_IRQ_ENABLE 8'h1B
`define FIE_BIT_ON_POWER_ON_0 0
`define FIE_BIT_ON_POWER_ON_1 1
`define FIE_BIT_ON_SHUTDOWN 2
`define FIE_BIT_MON2 1
`define FIE_BIT_MON3 2
`define FIE_BIT_MON4 3
`define FIE_BIT_PACKET_ERROR 0
`define FIE_BIT_THERMAL_TRIP 2
`define FIE_BIT_RUNTIME_CHECK 4
`define FIE_RESET_VALUE 8'h00
`define FIE_CRC_POLY 8'h07
`define FIE_CRC_INIT 8'hFF
`define FIE_NUM_REGS 6
`endif

//--- src/fie_crc8_step.v
// Serial CRC-8 engine that folds one register byte per cycle into a running value
`timescale 1ns/1ps
`include "fie_cfg_regs.vh"
module fie_crc8_step (
    input wire clk_sys_in,       // System clock
    input wire rstn_in,          // Synchronous reset, active low
    input wire start_in,         // Begin a new pass, restarts from the initial value
    input wire byte_valid_in,    // Byte on byte_in is to be folded in
    input wire [7:0] byte_in,    // Register byte
    output reg [7:0] crc_out     // Running CRC value
);

    // One byte of CRC-8, bitwise MSB first; a loop keeps the logic small
    function [7:0] fie_crc8_byte;
        input [7:0] crc;
        input [7:0] data;
        integer i;
        reg [7:0] c;
        begin
            c = crc ^ data;
            for (i = 0; i < 8; i = i + 1) begin
                if (c[7]) begin
                    c = {c[6:0], 1'b0} ^ `FIE_CRC_POLY;
                end else begin
                    c = {c[6:0], 1'b0};
                end
            end
            fie_crc8_byte = c;
        end
    endfunction

    // Running value
    always @(posedge clk_sys_in) begin
        if (!rstn_in) begin
            crc_out <= `FIE_CRC_INIT;
        end else if (start_in) begin
            crc_out <= `FIE_CRC_INIT;
        end else if (byte_valid_in) begin
            crc_out <= fie_crc8_byte(crc_out, byte_in);
        end
    end

endmodule

//--- src/fie_sync2.v
// Two flip-flop synchroniser for a bundle of asynchronous levels
`timescale 1ns/1ps
module fie_sync2 #(
    parameter WIDTH = 1
) (
    input wire clk_sys_in,           // System clock
    input wire rstn_in,              // Synchronous reset, active low
    input wire [WIDTH-1:0] async_in, // Levels from outside the domain
    output reg [WIDTH-1:0] sync_out  // Synchronised levels
);

    reg [WIDTH-1:0] meta;

    // First stage feeds only the second stage
    always @(posedge clk_sys_in) begin
        if (!rstn_in) begin
            meta <= {WIDTH{1'b0}};
            sync_out <= {WIDTH{1'b0}};
        end else begin
            meta <= async_in;
            sync_out <= meta;
        end
    end

endmodule

//--- src/fie_fault_irq_cfg.v
// Fault interrupt enable and self-test run configuration bank with runtime map CRC check
`timescale 1ns/1ps
`include "fie_cfg_regs.vh"
module fie_fault_irq_cfg (
    input wire clk_sys_in,                   // System clock, 25 MHz
    input wire rstn_in,                      // Synchronous reset, active low
    input wire [7:0] reg_addr_in,            // Register address from the serial bus engine
    input wire reg_wr_in,                    // Write strobe, one cycle
    input wire [7:0] reg_wdata_in,           // Write data
    input wire reg_rd_in,                    // Read strobe, one cycle
    input wire por_done_in,                  // Power-on reset sequence finished, pulse
    input wire shutdown_entry_in,            // Device enters shutdown, pulse
    input wire [2:0] fast_uv_fault_in,       // Fast undervoltage faults, channels 4..2, async
    input wire [2:0] slow_uv_fault_in,       // Slow undervoltage faults, channels 4..2, async
    input wire [2:0] fast_ov_fault_in,       // Fast overvoltage faults, channels 4..2, async
    input wire [2:0] slow_ov_fault_in,       // Slow overvoltage faults, channels 4..2, async
    input wire thermal_trip_in,              // Thermal shutdown event, async
    input wire packet_error_in,              // Packet error check fault, pulse from bus engine
    input wire crc_fault_clear_in,           // Clear of the map check fault status, pulse
    input wire [7:0] flip_inject_in,         // Test corruption of self-test config bits, pulse per bit
    output reg [7:0] reg_rdata_out,          // Read data
    output reg reg_rvalid_out,               // Read data valid, one cycle
    output reg self_test_request_out,        // Request to run the self test, one cycle
    output reg crc_fault_status_out,         // Runtime map check mismatch, sticky
    output reg interrupt_out_n               // Interrupt, active low
);

    // One-hot states of the map check sequencer
    localparam ST_IDLE = 3'b001;
    localparam ST_SCAN = 3'b010;
    localparam ST_DONE = 3'b100;

    // Stored bank, reserved bits kept as written
    reg [7:0] self_test_run_config;
    reg [7:0] fast_undervolt_irq_enable;
    reg [7:0] slow_undervolt_irq_enable;
    reg [7:0] fast_overvolt_irq_enable;
    reg [7:0] slow_overvolt_irq_enable;
    reg [7:0] control_fault_irq_enable;

    // Map check sequencer and reference
    reg [2:0] state;
    reg [2:0] next_state;
    reg [2:0] scan_idx;
    reg [7:0] ref_crc;
    reg ref_stale;
    reg scan_is_ref;
    reg [7:0] scan_byte;

    // Engine result, synchronised pins and decoded strobes
    wire [7:0] crc_now;
    wire [11:0] volt_sync;
    wire thermal_sync;
    wire map_write;
    wire irq_any;

    ////////////////////////////////////////////////////////////////////////////
    // Address decode helper for the scan path, index to register offset
    // Indices past five fold onto the last byte so the case stays complete
    function [7:0] fie_addr_of;
        input [2:0] idx;
        begin
            case (idx)
                3'd0: fie_addr_of = `FIE_ADDR_SELF_TEST_RUN_CONFIG;
                3'd1: fie_addr_of = `FIE_ADDR_FAST_UNDERVOLT_IRQ_ENABLE;
                3'd2: fie_addr_of = `FIE_ADDR_SLOW_UNDERVOLT_IRQ_ENABLE;
                3'd3: fie_addr_of = `FIE_ADDR_FAST_OVERVOLT_IRQ_ENABLE;
                3'd4: fie_addr_of = `FIE_ADDR_SLOW_OVERVOLT_IRQ_ENABLE;
                default: fie_addr_of = `FIE_ADDR_CONTROL_FAULT_IRQ_ENABLE;
            endcase
        end
    endfunction

    // Select a stored byte by address; unmapped addresses read zero
    function [7:0] fie_pick;
        input [7:0] addr;
        input [47:0] regs;
        begin
            case (addr)
                `FIE_ADDR_SELF_TEST_RUN_CONFIG: fie_pick = regs[7:0];
                `FIE_ADDR_FAST_UNDERVOLT_IRQ_ENABLE: fie_pick = regs[15:8];
                `FIE_ADDR_SLOW_UNDERVOLT_IRQ_ENABLE: fie_pick = regs[23:16];
                `FIE_ADDR_FAST_OVERVOLT_IRQ_ENABLE: fie_pick = regs[31:24];
                `FIE_ADDR_SLOW_OVERVOLT_IRQ_ENABLE: fie_pick = regs[39:32];
                `FIE_ADDR_CONTROL_FAULT_IRQ_ENABLE: fie_pick = regs[47:40];
                default: fie_pick = 8'h00;
            endcase
        end
    endfunction

    // Both views put the 12h byte in bits 7:0 and climb by offset, as the pick function expects
    // map_regs feeds the scan, all_regs the read port
    wire [47:0] all_regs = {control_fault_irq_enable, slow_overvolt_irq_enable, fast_overvolt_irq_enable,
                            slow_undervolt_irq_enable, fast_undervolt_irq_enable, self_test_run_config};
    wire [47:0] map_regs = {control_fault_irq_enable, slow_overvolt_irq_enable, fast_overvolt_irq_enable,
                            slow_undervolt_irq_enable, fast_undervolt_irq_enable, self_test_run_config};

    ////////////////////////////////////////////////////////////////////////////
    // Fault pins come from the analog side and another clock, so resync first
    // Packet error, strobes and clear share this clock and skip the delay
    fie_sync2 #(
        .WIDTH(13)
    ) u_sync (
        .clk_sys_in(clk_sys_in),
        .rstn_in(rstn_in),
        .async_in({thermal_trip_in, slow_ov_fault_in, fast_ov_fault_in, slow_uv_fault_in, fast_uv_fault_in}),
        .sync_out({thermal_sync, volt_sync})
    );

    // Only the six mapped places change the map, so only they drop the reference
    assign map_write = reg_wr_in && (fie_pick(reg_addr_in, 48'hFFFF_FFFF_FFFF) != 8'h00);

    ////////////////////////////////////////////////////////////////////////////
    // Register writes; reserved bits are stored like any other bit
    always @(posedge clk_sys_in) begin
        if (!rstn_in) begin
            self_test_run_config <= `FIE_RESET_VALUE;
            fast_undervolt_irq_enable <= `FIE_RESET_VALUE;
            slow_undervolt_irq_enable <= `FIE_RESET_VALUE;
            fast_overvolt_irq_enable <= `FIE_RESET_VALUE;
            slow_overvolt_irq_enable <= `FIE_RESET_VALUE;
            control_fault_irq_enable <= `FIE_RESET_VALUE;
        end else begin
            // Corruption port stands in for an upset; it bypasses the reference update
            // A bus write in the same cycle wins, so the host reads back what it wrote
            self_test_run_config <= self_test_run_config ^ flip_inject_in;
            if (reg_wr_in) begin
                case (reg_addr_in)
                    `FIE_ADDR_SELF_TEST_RUN_CONFIG: self_test_run_config <= reg_wdata_in;
                    `FIE_ADDR_FAST_UNDERVOLT_IRQ_ENABLE: fast_undervolt_irq_enable <= reg_wdata_in;
                    `FIE_ADDR_SLOW_UNDERVOLT_IRQ_ENABLE: slow_undervolt_irq_enable <= reg_wdata_in;
                    `FIE_ADDR_FAST_OVERVOLT_IRQ_ENABLE: fast_overvolt_irq_enable <= reg_wdata_in;
                    `FIE_ADDR_SLOW_OVERVOLT_IRQ_ENABLE: slow_overvolt_irq_enable <= reg_wdata_in;
                    `FIE_ADDR_CONTROL_FAULT_IRQ_ENABLE: control_fault_irq_enable <= reg_wdata_in;
                    default: begin
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read port answers one cycle after the strobe
    // Data holds until the next read; unmapped places answer zero with a valid pulse
    always @(posedge clk_sys_in) begin
        if (!rstn_in) begin
            reg_rdata_out <= 8'h00;
            reg_rvalid_out <= 1'b0;
        end else begin
            reg_rvalid_out <= reg_rd_in;
            if (reg_rd_in) begin
                reg_rdata_out <= fie_pick(reg_addr_in, all_regs);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Self-test request on power-on (either redundant bit) or on shutdown entry
    // Either power-on bit alone is enough, so one upset bit cannot block the test
    wire por_request;
    wire shutdown_request;

    assign por_request = por_done_in && (self_test_run_config[`FIE_BIT_ON_POWER_ON_0] ||
                                         self_test_run_config[`FIE_BIT_ON_POWER_ON_1]);
    assign shutdown_request = shutdown_entry_in && self_test_run_config[`FIE_BIT_ON_SHUTDOWN];

    // One-cycle request pulse per trigger
    always @(posedge clk_sys_in) begin
        if (!rstn_in) begin
            self_test_request_out <= 1'b0;
        end else begin
            self_test_request_out <= por_request || shutdown_request;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Scan sequencer: walks all six bytes back to back, forever, while enabled
    // A mapped write drops the pass at once; the rebuilt reference then covers
    // the new contents, so an intended change never reads as an upset
    always @* begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (control_fault_irq_enable[`FIE_BIT_RUNTIME_CHECK] || ref_stale) begin
                    next_state = ST_SCAN;
                end
            end
            ST_SCAN: begin
                if (map_write) begin
                    next_state = ST_IDLE;
                end else if (scan_idx == 3'd5) begin
                    next_state = ST_DONE;
                end
            end
            // One cycle to compare or store, then back to restart the engine
            ST_DONE: next_state = ST_IDLE;
            default: next_state = ST_IDLE;
        endcase
    end

    // Byte fed to the CRC engine
    // Scan order follows the offsets, independent of the read mux
    always @* begin
        scan_byte = fie_pick(fie_addr_of(scan_idx), map_regs);
    end

    // Engine restarts from its initial value whenever the sequencer idles
    fie_crc8_step u_crc (
        .clk_sys_in(clk_sys_in),
        .rstn_in(rstn_in),
        .start_in(state == ST_IDLE),
        .byte_valid_in(state == ST_SCAN),
        .byte_in(scan_byte),
        .crc_out(crc_now)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Reference handling and mismatch flag; set beats clear
    // A pass begun on a stale reference only rebuilds it and never compares
    // Clear loses to a set in the same cycle, so no mismatch is ever lost
    always @(posedge clk_sys_in) begin
        if (!rstn_in) begin
            state <= ST_IDLE;
            scan_idx <= 3'd0;
            ref_crc <= 8'h00;
            ref_stale <= 1'b1;
            scan_is_ref <= 1'b1;
            crc_fault_status_out <= 1'b0;
        end else begin
            state <= next_state;
            if (state == ST_SCAN && next_state == ST_SCAN) begin
                scan_idx <= scan_idx + 3'd1;
            end else begin
                scan_idx <= 3'd0;
            end
            if (state == ST_IDLE && next_state == ST_SCAN) begin
                scan_is_ref <= ref_stale;
            end
            if (map_write) begin
                ref_stale <= 1'b1;
            end else if (state == ST_DONE && scan_is_ref) begin
                ref_stale <= 1'b0;
                ref_crc <= crc_now;
            end
            if (state == ST_DONE && !scan_is_ref && !ref_stale && crc_now != ref_crc) begin
                crc_fault_status_out <= 1'b1;
            end else if (crc_fault_clear_in) begin
                crc_fault_status_out <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt: only enabled sources reach the pin, status is independent
    // Each source is masked on its own, so a wrong bit position shows in one term only
    wire fast_uv_hit;
    wire slow_uv_hit;
    wire fast_ov_hit;
    wire slow_ov_hit;
    wire thermal_hit;
    wire packet_hit;
    wire map_check_hit;

    // Enable bits 3..1 line up with synchronised channels 4..2
    assign fast_uv_hit = |(volt_sync[2:0] & fast_undervolt_irq_enable[3:1]);
    assign slow_uv_hit = |(volt_sync[5:3] & slow_undervolt_irq_enable[3:1]);
    assign fast_ov_hit = |(volt_sync[8:6] & fast_overvolt_irq_enable[3:1]);
    assign slow_ov_hit = |(volt_sync[11:9] & slow_overvolt_irq_enable[3:1]);

    // Thermal pin is synchronised; packet error already runs on this clock
    assign thermal_hit = thermal_sync & control_fault_irq_enable[`FIE_BIT_THERMAL_TRIP];
    assign packet_hit = packet_error_in & control_fault_irq_enable[`FIE_BIT_PACKET_ERROR];
    // Status stays set while unmapped; only the pin follows the enable
    assign map_check_hit = crc_fault_status_out & control_fault_irq_enable[`FIE_BIT_RUNTIME_CHECK];

    // Any enabled cause pulls the pin low
    assign irq_any = fast_uv_hit | slow_uv_hit | fast_ov_hit | slow_ov_hit |
                     thermal_hit | packet_hit | map_check_hit;

    // Registered so the pin never glitches
    // Two sync stages plus this register: a pin fault shows three edges later
    always @(posedge clk_sys_in) begin
        if (!rstn_in) begin
            interrupt_out_n <= 1'b1;
        end else begin
            interrupt_out_n <= ~irq_any;
        end
    end

endmodule

//--- tb/fie_cfg_chk.sv
// Assertion checker for the fault enable and self-test configuration bank
`timescale 1ns/1ps
module fie_cfg_chk (
    input wire clk_sys_in, // Clock
    input wire rstn_in, // Reset, active low
    input wire [7:0] reg_addr_in, // Address
    input wire reg_wr_in, // Write strobe
    input wire [7:0] reg_wdata_in, // Write data
    input wire reg_rd_in, // Read strobe
    input wire por_done_in, // Power-on done
    input wire shutdown_entry_in, // Shutdown entry
    input wire [2:0] fast_uv_fault_in, // Faults
    input wire [2:0] slow_uv_fault_in, // Faults
    input wire [2:0] fast_ov_fault_in, // Faults
    input wire [2:0] slow_ov_fault_in, // Faults
    input wire thermal_trip_in, // Thermal event
    input wire packet_error_in, // Packet error
    input wire crc_fault_clear_in, // Status clear
    input wire [7:0] flip_inject_in, // Upset injection
    input wire [7:0] reg_rdata_out, // Read data
    input wire reg_rvalid_out, // Read valid
    input wire self_test_request_out, // Self-test request
    input wire crc_fault_status_out, // Check status
    input wire interrupt_out_n // Interrupt, active low
);
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!rstn_in);
    reg [7:0] st, fuv, suv, fov, sov, ctl;
    ////////////////////////////////////////
    // Shadow of the bank, kept from bus writes since the checker cannot see inside
    always @(posedge clk_sys_in) begin
        if (!rstn_in) begin
            {st, fuv, suv, fov, sov, ctl} <= 48'h0;
        end else begin
            st <= (reg_wr_in && reg_addr_in == 8'h12) ? reg_wdata_in : st ^ flip_inject_in;
            if (reg_wr_in && reg_addr_in == 8'h13) fuv <= reg_wdata_in;
            if (reg_wr_in && reg_addr_in == 8'h14) suv <= reg_wdata_in;
            if (reg_wr_in && reg_addr_in == 8'h15) fov <= reg_wdata_in;
            if (reg_wr_in && reg_addr_in == 8'h16) sov <= reg_wdata_in;
            if (reg_wr_in && reg_addr_in == 8'h1B) ctl <= reg_wdata_in;
        end
    end
    // Raw enabled causes; quiet needs four clean cycles to cover the synchroniser
    wire en_hit = |({fast_uv_fault_in, slow_uv_fault_in, fast_ov_fault_in, slow_ov_fault_in}
        & {fuv[3:1], suv[3:1], fov[3:1], sov[3:1]}) | (thermal_trip_in & ctl[2]);
    wire quiet = !en_hit && !(packet_error_in && ctl[0]) && !(crc_fault_status_out && ctl[4]);
    wire mapped = reg_addr_in inside {8'h12, 8'h13, 8'h14, 8'h15, 8'h16, 8'h1B};
    wire req_due = (por_done_in && (st[0] || st[1])) || (shutdown_entry_in && st[2]);
    sequence s_fault_held; en_hit [*3]; endsequence
    sequence s_quiet; quiet [*4]; endsequence
    a_read_answer: assert property (reg_rd_in |=> reg_rvalid_out) else $error("read not answered");
    a_rvalid_cause: assert property (reg_rvalid_out |-> $past(reg_rd_in)) else $error("stray read valid");
    a_unmapped_zero: assert property (reg_rd_in && !mapped |=> reg_rdata_out == 8'h00)
        else $error("unmapped read not zero");
    a_control_readback: assert property (reg_rd_in && reg_addr_in == 8'h1B |=> reg_rdata_out == $past(ctl))
        else $error("control enable readback wrong");
    a_request_due: assert property (req_due |=> self_test_request_out) else $error("self test not requested");
    a_request_cause: assert property (self_test_request_out |-> $past(req_due))
        else $error("self test requested without cause");
    a_fault_irq: assert property (s_fault_held |=> !interrupt_out_n)
        else $error("enabled fault gave no interrupt");
    a_packet_irq: assert property (packet_error_in && ctl[0] |=> !interrupt_out_n)
        else $error("packet error gave no interrupt");
    a_crc_irq: assert property (crc_fault_status_out && ctl[4] |=> !interrupt_out_n)
        else $error("check fault not mapped");
    a_status_sticky: assert property (crc_fault_status_out && !crc_fault_clear_in |=> crc_fault_status_out)
        else $error("check status dropped");
    a_irq_quiet: assert property (s_quiet |=> interrupt_out_n) else $error("interrupt without enabled cause");
endmodule
bind fie_fault_irq_cfg fie_cfg_chk fie_cfg_chk_inst (.*);

//--- tb/fie_host.sv
// Host model issuing register reads and writes to the configuration bank
`timescale 1ns/1ps
module fie_host (
    input wire clk_sys_in, // Clock
    input wire [7:0] reg_rdata_in, // Read data
    input wire reg_rvalid_in, // Read valid
    output logic [7:0] reg_addr_out = 8'h00, // Address
    output logic reg_wr_out = 1'b0, // Write strobe
    output logic [7:0] reg_wdata_out = 8'hFF, // Write data
    output logic reg_rd_out = 1'b0 // Read strobe
);
    ////////////////////////////////////////
    // One-cycle write; idle address and data turn over so stale values never look valid
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys_in);
        #1;
        reg_addr_out = a;
        reg_wdata_out = d;
        reg_wr_out = 1'b1;
        @(posedge clk_sys_in);
        #1;
        reg_wr_out = 1'b0;
        reg_addr_out = ~a;
        reg_wdata_out = ~d;
    endtask
    // One-cycle read; data is taken with the valid pulse, waited for a bounded time
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        int n;
        @(posedge clk_sys_in);
        #1;
        reg_addr_out = a;
        reg_rd_out = 1'b1;
        @(posedge clk_sys_in);
        #1;
        reg_rd_out = 1'b0;
        reg_addr_out = ~a;
        n = 0;
        while (reg_rvalid_in !== 1'b1 && n < 4) begin
            @(posedge clk_sys_in);
            #1;
            n++;
        end
        d = (reg_rvalid_in === 1'b1) ? reg_rdata_in : 8'hXX;
    endtask
endmodule

//--- tb/fie_fault_irq_cfg_tb_top.sv
// Testbench for the fault enable and self-test configuration bank
`timescale 1ns/1ps
module fie_fault_irq_cfg_tb_top;
    logic clk_sys_in = 1'b0;
    logic rstn_in = 1'b0;
    logic por = 1'b0, shdn = 1'b0, therm = 1'b0, pkt = 1'b0, clr = 1'b0;
    logic [7:0] flip = 8'h00, addr, wdata, rdata, rd_val;
    logic [2:0] flt [4] = '{default: 3'h0};
    logic wr, rd, rvalid, req, status, irq_n;
    int fail_count = 0, num_checks = 0;
    logic [7:0] map [6] = '{8'h12, 8'h13, 8'h14, 8'h15, 8'h16, 8'h1B};
    fie_fault_irq_cfg fie_fault_irq_cfg_inst (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .reg_addr_in(addr),
        .reg_wr_in(wr), .reg_wdata_in(wdata), .reg_rd_in(rd), .por_done_in(por), .shutdown_entry_in(shdn),
        .fast_uv_fault_in(flt[0]), .slow_uv_fault_in(flt[1]), .fast_ov_fault_in(flt[2]),
        .slow_ov_fault_in(flt[3]), .thermal_trip_in(therm), .packet_error_in(pkt), .crc_fault_clear_in(clr),
        .flip_inject_in(flip), .reg_rdata_out(rdata), .reg_rvalid_out(rvalid), .self_test_request_out(req),
        .crc_fault_status_out(status), .interrupt_out_n(irq_n));
    fie_host fie_host_inst (.clk_sys_in(clk_sys_in), .reg_rdata_in(rdata), .reg_rvalid_in(rvalid),
        .reg_addr_out(addr), .reg_wr_out(wr), .reg_wdata_out(wdata), .reg_rd_out(rd));
    ////////////////////////////////////////
    // 25 MHz clock
    initial begin
        forever #20 clk_sys_in = ~clk_sys_in;
    end
    // Compare and count; four-state compare so an unknown never matches
    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // Inputs change 1 ns after the edge, away from sampling
    task automatic step(input int n);
        repeat (n) @(posedge clk_sys_in);
        #1;
    endtask
    // Reset values, store and read back with reserved bits set, unmapped place
    task automatic t_regs;
        foreach (map[i]) begin
            fie_host_inst.rd(map[i], rd_val);
            chk("reset value", rd_val, 8'h00);
        end
        foreach (map[i]) fie_host_inst.wr(map[i], map[i] ^ 8'hA5);
        fie_host_inst.wr(8'h17, 8'hFF);
        foreach (map[i]) begin
            fie_host_inst.rd(map[i], rd_val);
            chk("stored byte", rd_val, map[i] ^ 8'hA5);
        end
        fie_host_inst.rd(8'h17, rd_val);
        chk("unmapped read", rd_val, 8'h00);
        chk("status after writes", {7'h0, status}, 8'h00);
        foreach (map[i]) fie_host_inst.wr(map[i], 8'h00);
    endtask
    // Run settings 01h to 04h and 00h against the power-on and shutdown triggers
    task automatic t_self_test;
        logic [7:0] cfg [5] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h00};
        logic [4:0] on_por = 5'b00111;
        logic [4:0] on_shdn = 5'b01000;
        for (int i = 0; i < 5; i++) begin
            fie_host_inst.wr(cfg[i], cfg[i]);
            fie_host_inst.wr(8'h12, cfg[i]);
            step(1);
            por = 1'b1;
            step(1);
            por = 1'b0;
            chk("power-on request", {7'h0, req}, {7'h0, on_por[i]});
            step(1);
            chk("request one cycle", {7'h0, req}, 8'h00);
            shdn = 1'b1;
            step(1);
            shdn = 1'b0;
            chk("shutdown request", {7'h0, req}, {7'h0, on_shdn[i]});
        end
    endtask
    // Every group and channel: enabled raises the interrupt, disabled keeps it off
    task automatic t_faults;
        for (int g = 0; g < 4; g++) begin
            for (int c = 0; c < 3; c++) begin
                fie_host_inst.wr(8'(8'h13 + g), 8'h02 << c);
                step(1);
                flt[g][c] = 1'b1;
                step(4);
                chk("enabled fault", {7'h0, irq_n}, 8'h00);
                fie_host_inst.wr(8'(8'h13 + g), ~(8'h02 << c));
                step(2);
                chk("disabled fault", {7'h0, irq_n}, 8'h01);
                flt[g][c] = 1'b0;
                fie_host_inst.wr(8'(8'h13 + g), 8'h00);
            end
        end
    endtask
    // Thermal and packet faults, disabled first, then enabled while present
    task automatic t_control;
        fie_host_inst.wr(8'h1B, 8'hFB);
        therm = 1'b1;
        step(4);
        chk("thermal off", {7'h0, irq_n}, 8'h01);
        fie_host_inst.wr(8'h1B, 8'h04);
        step(2);
        chk("thermal on", {7'h0, irq_n}, 8'h00);
        therm = 1'b0;
        fie_host_inst.wr(8'h1B, 8'hFE);
        step(4);
        pkt = 1'b1;
        step(2);
        chk("packet off", {7'h0, irq_n}, 8'h01);
        fie_host_inst.wr(8'h1B, 8'h01);
        step(1);
        chk("packet on", {7'h0, irq_n}, 8'h00);
        pkt = 1'b0;
        fie_host_inst.wr(8'h1B, 8'h00);
    endtask
    // Upset of a stored bit is caught without bus traffic; status is sticky
    task automatic t_crc;
        int n;
        fie_host_inst.wr(8'h1B, 8'h10);
        step(20);
        chk("no false fault", {7'h0, status}, 8'h00);
        flip = 8'h01;
        step(1);
        flip = 8'h00;
        n = 0;
        while (status !== 1'b1 && n < 30) begin
            step(1);
            n++;
        end
        chk("upset caught", {7'h0, status}, 8'h01);
        step(1);
        chk("check mapped", {7'h0, irq_n}, 8'h00);
        fie_host_inst.wr(8'h1B, 8'h00);
        step(2);
        chk("check unmapped", {7'h0, irq_n, status}, 8'h03);
        clr = 1'b1;
        step(1);
        clr = 1'b0;
        step(1);
        chk("status cleared", {7'h0, status}, 8'h00);
    endtask
    // Counts, verdict and end of run
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // Main sequence after a 12 cycle reset
    initial begin
        repeat (12) @(posedge clk_sys_in);
        #1;
        rstn_in = 1'b1;
        t_regs;
        t_self_test;
        t_faults;
        t_control;
        t_crc;
        wrap_up;
    end
    // Watchdog well past the expected run length
    initial begin
        #(40 * 5000);
        fail_count++;
        wrap_up;
    end
endmodule
